/* design/mrs_tx_end.sv */
// Purpose: multiplex side: CIF counter, ensemble and configuration FIGs, reconfiguration timing
// Assumes: software orders a reconfiguration through the request register
// Notes: all FIGs of a frame go in its first FIB, one beat per cycle
// Summary of operation
// R1: primary component always sent with id zero
// R2: receiver finds component id by sub-channel match
// R3: stream audio primary means short id, else long
// R4: packet component resolved through its SCId
// R5: ensemble id is country plus 12-bit reference
// R6: change flags code none, legacy parts, full
// R7: transmitter only ever sends flags 00 or 11
// R8: receiver also honours legacy partial flags
// R9: alarm flag gates alarm interruptions everywhere
// R10: CIF count steps each 24 ms, modulo 5000
// R11: occurrence field holds target low CIF count
// R12: ensemble FIG first in first FIB, frame
// R13: configuration FIG second in that FIB
// R14: configuration carries six-bit service total
// R15: configuration count increments per reconfiguration, mod 1024
// R16: receiver trusts stored config on count match
// R17: each config message flags current or next
// R18: pending change shows flags 11 with occurrence
// R19: switch at first CIF matching occurrence value
// R20: configuration stays unchanged for 250 CIFs
// R21: shrinking sub-channel changes fifteen CIFs early
// R22: reconfiguration instant may align to superframes
// R23: receiver shadows next config, swaps at switch
// R24: receiver compares occurrence every CIF, across wrap
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
module mrs_tx_end #(
  parameter int unsigned CIF_CYCLES = mrs_pkg::CIF_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  mrs_link_if.tx link
);
  localparam int TW = $clog2(CIF_CYCLES);
  localparam logic [TW-1:0] TMR_LAST = TW'(CIF_CYCLES - 1);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_EI = 5'b00010, S_CI = 5'b00100, S_CN = 5'b01000, S_SC = 5'b10000
  } mrs_txst_t;

  logic wait_reg, wait_next;
  logic [31:0] rd_reg, rd_next;
  mrs_pkg::mrs_ens_t ens_reg, ens_next;
  mrs_pkg::mrs_req_t req_reg, req_next;
  mrs_pkg::mrs_comp_t comp_reg, comp_next;
  logic [31:0] sid_reg, sid_next;
  logic [5:0] svc_reg, svc_next;
  logic [7:0] stab_reg, stab_next;
  logic [TW-1:0] tmr_reg, tmr_next;
  logic [1:0] fpos_reg, fpos_next;
  logic start_reg;
  mrs_txst_t st_reg, st_next;
  logic strobe_reg, fv_reg, fv_next, cn_reg, cn_next, shr_reg, shr_next;
  logic [4:0] ext_reg, ext_next;
  logic [1:0] slot_reg, slot_next, chg_reg, chg_next;
  logic [5:0] osvc_reg, osvc_next;
  logic [9:0] ocnt_reg, ocnt_next;
  logic [31:0] sido_reg, sido_next;
  logic tick, act, low_wrap, bus_wr;
  logic [7:0] low;
  logic [4:0] high;
  logic [9:0] cnt;
  logic [7:0] occ_m15;
  logic [31:0] wmask;
  mrs_pkg::mrs_req_t wreq;
  mrs_pkg::mrs_stat_t stat;

  // CIF count in two parts, low modulo 250, high modulo 20
  mrs_modcnt #(.W(8), .LAST(mrs_pkg::LOW_LAST)) u_low (
    .clk_sys(clk_sys), .nrst(nrst), .inc(tick), .count(low), .wrap(low_wrap)); // [R10]
  mrs_modcnt #(.W(5), .LAST(mrs_pkg::HIGH_LAST)) u_high (
    .clk_sys(clk_sys), .nrst(nrst), .inc(low_wrap), .count(high), .wrap()); // [R10]
  // configuration count steps once per reconfiguration
  mrs_modcnt #(.W(10), .LAST(mrs_pkg::CNT_LAST)) u_cnt (
    .clk_sys(clk_sys), .nrst(nrst), .inc(act), .count(cnt), .wrap()); // [R15]

  assign tick = (tmr_reg == TMR_LAST); // [R10]
  // switch at the first CIF whose low count equals the occurrence value
  assign act = start_reg && req_reg.pend && (low == req_reg.occ); // [R19]
  assign occ_m15 = (req_reg.occ >= mrs_pkg::SHRINK_LEAD) ? req_reg.occ - mrs_pkg::SHRINK_LEAD
    : req_reg.occ + (mrs_pkg::LOW_MOD - mrs_pkg::SHRINK_LEAD);
  assign bus_wr = avs_write && !wait_reg;
  assign wmask = mrs_pkg::be_mask(avs_byteenable);
  assign wreq = mrs_pkg::mrs_req_t'((req_reg & ~wmask) | (avs_writedata & wmask));
  assign stat = '{rsv: '0, svc: svc_reg, pend: req_reg.pend, cnt: cnt, high: high, low: low};

  // CIF timer, frame position and stability count
  always_comb begin
    tmr_next = tick ? '0 : tmr_reg + 1'b1;
    fpos_next = tick ? fpos_reg + 1'b1 : fpos_reg;
    stab_next = stab_reg;
    if (act) begin
      stab_next = '0; // [R20]
    end else if (start_reg && (stab_reg < mrs_pkg::STABLE_CIFS)) begin
      stab_next = stab_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmr_reg <= '0;
      fpos_reg <= mrs_pkg::FRAME_FIRST;
      stab_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      fpos_reg <= fpos_next;
      stab_reg <= stab_next;
      start_reg <= tick;
    end
  end

  // avalon slave: one wait cycle, then the access completes
  always_comb begin
    wait_next = !((avs_read || avs_write) && wait_reg);
    rd_next = rd_reg;
    ens_next = ens_reg;
    req_next = req_reg;
    comp_next = comp_reg;
    sid_next = sid_reg;
    svc_next = svc_reg;
    if (avs_read && wait_reg) begin
      unique case (avs_address)
        mrs_pkg::TR_ENS: rd_next = ens_reg;
        mrs_pkg::TR_REQ: rd_next = req_reg;
        mrs_pkg::TR_SID: rd_next = sid_reg;
        mrs_pkg::TR_COMP: rd_next = comp_reg;
        mrs_pkg::TR_STAT: rd_next = stat;
        default: rd_next = '0;
      endcase
    end
    if (bus_wr && avs_address == mrs_pkg::TR_ENS) begin
      ens_next = (ens_reg & ~wmask) | (avs_writedata & wmask); // [R5]
      ens_next.rsv = '0;
    end
    if (bus_wr && avs_address == mrs_pkg::TR_SID) begin
      sid_next = (sid_reg & ~wmask) | (avs_writedata & wmask);
    end
    if (bus_wr && avs_address == mrs_pkg::TR_COMP) begin
      comp_next = (comp_reg & ~wmask) | (avs_writedata & wmask);
      comp_next.rsv = '0;
    end
    // a new order is taken only after 250 stable CIFs and with none pending
    if (bus_wr && avs_address == mrs_pkg::TR_REQ && wreq.go) begin
      if (!req_reg.pend && stab_reg >= mrs_pkg::STABLE_CIFS // [R20]
          && (!wreq.align || (wreq.occ % mrs_pkg::SF_LEN) == '0)) begin // [R22]
        req_next.svc = wreq.svc;
        req_next.occ = wreq.occ; // [R11]
        req_next.shrink = wreq.shrink;
        req_next.align = wreq.align;
        req_next.pend = 1'b1; // [R18]
        req_next.refused = 1'b0;
      end else begin
        req_next.refused = 1'b1;
      end
    end
    if (act) begin
      svc_next = req_reg.svc;
      req_next.pend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
      rd_reg <= '0;
      ens_reg <= '0;
      req_reg <= '0;
      comp_reg <= '0;
      sid_reg <= '0;
      svc_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      ens_reg <= ens_next;
      req_reg <= req_next;
      comp_reg <= comp_next;
      sid_reg <= sid_next;
      svc_reg <= svc_next;
    end
  end

  // FIG sequencer: one beat per cycle at the start of each transmission frame
  always_comb begin
    st_next = st_reg;
    fv_next = 1'b0;
    ext_next = ext_reg;
    slot_next = slot_reg;
    cn_next = cn_reg;
    osvc_next = osvc_reg;
    ocnt_next = ocnt_reg;
    sido_next = comp_reg.pd ? sid_reg : (sid_reg & mrs_pkg::SID16_MASK); // [R3]
    chg_next = req_reg.pend ? mrs_pkg::CF_FULL : mrs_pkg::CF_NONE; // [R7] [R6] [R18]
    shr_next = start_reg && req_reg.pend && req_reg.shrink && (low == occ_m15); // [R21]
    unique case (st_reg)
      S_IDLE: begin
        if (start_reg && fpos_reg == mrs_pkg::FRAME_FIRST) begin
          st_next = S_EI; // [R12]
        end
      end
      S_EI: begin
        fv_next = 1'b1;
        ext_next = mrs_pkg::EXT_EI;
        slot_next = mrs_pkg::SLOT_EI; // [R12]
        cn_next = 1'b0;
        st_next = S_CI;
      end
      S_CI: begin
        fv_next = 1'b1;
        ext_next = mrs_pkg::EXT_CI;
        slot_next = mrs_pkg::SLOT_CI; // [R13]
        cn_next = 1'b0; // [R17]
        osvc_next = svc_reg; // [R14]
        ocnt_next = cnt;
        st_next = req_reg.pend ? S_CN : S_SC;
      end
      S_CN: begin
        fv_next = 1'b1;
        ext_next = mrs_pkg::EXT_CI;
        slot_next = mrs_pkg::SLOT_CN;
        cn_next = 1'b1; // [R17]
        osvc_next = req_reg.svc;
        ocnt_next = cnt + 1'b1; // [R15]
        st_next = S_SC;
      end
      S_SC: begin
        fv_next = 1'b1;
        ext_next = mrs_pkg::EXT_SC;
        slot_next = mrs_pkg::SLOT_SC;
        cn_next = 1'b0;
        st_next = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= S_IDLE;
      strobe_reg <= 1'b0;
      fv_reg <= 1'b0;
      ext_reg <= mrs_pkg::EXT_EI;
      slot_reg <= mrs_pkg::SLOT_EI;
      cn_reg <= 1'b0;
      osvc_reg <= '0;
      ocnt_reg <= '0;
      sido_reg <= '0;
      chg_reg <= mrs_pkg::CF_NONE;
      shr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      strobe_reg <= start_reg;
      fv_reg <= fv_next;
      ext_reg <= ext_next;
      slot_reg <= slot_next;
      cn_reg <= cn_next;
      osvc_reg <= osvc_next;
      ocnt_reg <= ocnt_next;
      sido_reg <= sido_next;
      chg_reg <= chg_next;
      shr_reg <= shr_next;
    end
  end

  // link outputs, all from flops except scids, which is tied to the constant SCIDS_PRI
  assign link.cif_strobe = strobe_reg;
  assign link.cif_low = low;
  assign link.cif_high = high;
  assign link.frame_pos = fpos_reg;
  assign link.fig_valid = fv_reg;
  assign link.fig_ext = ext_reg;
  assign link.fig_slot = slot_reg;
  assign link.cn = cn_reg;
  assign link.eid = {ens_reg.country, ens_reg.eref}; // [R5]
  assign link.chg = chg_reg;
  assign link.alarm = ens_reg.alarm;
  assign link.occ = req_reg.occ;
  assign link.svc = osvc_reg;
  assign link.cnt = ocnt_reg;
  assign link.sid = sido_reg; // [R3]
  assign link.pd = comp_reg.pd;
  assign link.scids = mrs_pkg::SCIDS_PRI; // [R1]
  assign link.ls = comp_reg.ls;
  assign link.subch = comp_reg.subch;
  assign link.scid = comp_reg.scid;
  assign link.shrink_go = shr_reg;
  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;
endmodule

/* shared/mrs_pkg.sv */
// Purpose: constants and register layouts shared by both ends of the multiplex signalling link
// Assumes: 100 MHz clk_sys, one CIF every 24 ms, transmission mode I
// Notes: register fields are packed structs, most significant field first
package mrs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CIF_US = 24000; // one CIF, in microseconds
  localparam int CIF_CYC = CIF_US * CLK_MHZ;
  localparam logic [7:0] LOW_LAST = 8'hf9; // low part 0..249
  localparam logic [4:0] HIGH_LAST = 5'h13; // high part 0..19
  localparam logic [9:0] CNT_LAST = 10'h3ff; // config count 0..1023
  localparam logic [7:0] LOW_MOD = 8'hfa;
  localparam logic [7:0] STABLE_CIFS = 8'hfa; // 250 CIFs, six seconds
  localparam logic [7:0] SHRINK_LEAD = 8'h0f; // n - 15
  localparam logic [7:0] SF_LEN = 8'h05; // longest audio superframe in CIFs
  localparam logic [1:0] CF_NONE = 2'h0;
  localparam logic [1:0] CF_FULL = 2'h3;
  localparam logic [4:0] EXT_EI = 5'h00;
  localparam logic [4:0] EXT_CI = 5'h07;
  localparam logic [4:0] EXT_SC = 5'h08;
  localparam logic [1:0] SLOT_EI = 2'h0;
  localparam logic [1:0] SLOT_CI = 2'h1;
  localparam logic [1:0] SLOT_CN = 2'h2;
  localparam logic [1:0] SLOT_SC = 2'h3;
  localparam logic [1:0] FRAME_FIRST = 2'h0;
  localparam logic [3:0] SCIDS_PRI = 4'h0;
  localparam logic [31:0] SID16_MASK = 32'h0000ffff;
  localparam logic [2:0] TR_ENS = 3'h0;
  localparam logic [2:0] TR_REQ = 3'h1;
  localparam logic [2:0] TR_SID = 3'h2;
  localparam logic [2:0] TR_COMP = 3'h3;
  localparam logic [2:0] TR_STAT = 3'h4;
  localparam logic [2:0] RR_KEY = 3'h0;
  localparam logic [2:0] RR_STAT = 3'h1;
  localparam logic [2:0] RR_CIF = 3'h2;
  localparam logic [2:0] RR_SID = 3'h3;
  typedef struct packed {logic [14:0] rsv; logic alarm; logic [3:0] country; logic [11:0] eref;} mrs_ens_t;
  typedef struct packed {
    logic go; logic [5:0] rsv2; logic refused; logic pend; logic [4:0] rsv1;
    logic align; logic shrink; logic [7:0] occ; logic [1:0] rsv0; logic [5:0] svc;
  } mrs_req_t;
  typedef struct packed {logic [11:0] rsv; logic ls; logic [11:0] scid; logic [5:0] subch; logic pd;} mrs_comp_t;
  typedef struct packed {
    logic [1:0] rsv; logic [5:0] svc; logic pend; logic [9:0] cnt; logic [4:0] high; logic [7:0] low;
  } mrs_stat_t;
  typedef struct packed {logic [5:0] rsv; logic [9:0] stored; logic [2:0] rsv0; logic ls; logic [11:0] key;} mrs_key_t;
  typedef struct packed {
    logic [5:0] svc; logic shrink; logic complete; logic [3:0] scids; logic found;
    logic known; logic pend; logic alarm; logic [15:0] eid;
  } mrs_rstat_t;
  // byte enables to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage

/* shared/mrs_link_if.sv */
// Purpose: signalling link between multiplex transmitter and receiver decoder
// Assumes: both ends on clk_sys; the transmitter drives every signal
// Notes: fig_valid marks one FIG beat; payload fields are valid with it
interface mrs_link_if;
  logic cif_strobe;
  logic [7:0] cif_low;
  logic [4:0] cif_high;
  logic [1:0] frame_pos;
  logic fig_valid;
  logic [4:0] fig_ext;
  logic [1:0] fig_slot;
  logic cn;
  logic [15:0] eid;
  logic [1:0] chg;
  logic alarm;
  logic [7:0] occ;
  logic [5:0] svc;
  logic [9:0] cnt;
  logic [31:0] sid;
  logic pd;
  logic [3:0] scids;
  logic ls;
  logic [5:0] subch;
  logic [11:0] scid;
  logic shrink_go;
  modport tx (output cif_strobe, cif_low, cif_high, frame_pos, fig_valid, fig_ext, fig_slot, cn, eid, chg,
    alarm, occ, svc, cnt, sid, pd, scids, ls, subch, scid, shrink_go);
  modport rx (input cif_strobe, cif_low, cif_high, frame_pos, fig_valid, fig_ext, fig_slot, cn, eid, chg,
    alarm, occ, svc, cnt, sid, pd, scids, ls, subch, scid, shrink_go);
endinterface

/* design/mrs_modcnt.sv */
// Purpose: modulo counter with wrap pulse
// Assumes: LAST is the final count before wrap to zero
// Notes: wrap is combinational, for cascading
module mrs_modcnt #(
  parameter int W = 8,
  parameter logic [W-1:0] LAST = '1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic inc,
  output logic [W-1:0] count,
  output logic wrap
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  assign wrap = inc && (cnt_reg == LAST);
  assign count = cnt_reg;

  // next count
  always_comb begin
    cnt_next = cnt_reg;
    if (wrap) begin
      cnt_next = '0;
    end else if (inc) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* design/mrs_rx_end.sv */
// Purpose: receiver side signalling decoder for ensemble and configuration FIGs
// Assumes: link fields are valid in the cycle of fig_valid or cif_strobe
// Notes: next configuration is shadowed and swapped in at the switch CIF
module mrs_rx_end (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic alarm_enable,
  mrs_link_if.rx link
);
  logic wait_reg, wait_next;
  logic [31:0] rd_reg, rd_next;
  mrs_pkg::mrs_key_t key_reg, key_next;
  mrs_pkg::mrs_rstat_t rs_reg, rs_next;
  logic [7:0] occ_reg, occ_next, low_reg, low_next;
  logic [4:0] high_reg, high_next;
  logic [9:0] cnt_reg, cnt_next, shcnt_reg, shcnt_next;
  logic [5:0] shsvc_reg, shsvc_next, prim_reg, prim_next;
  logic shok_reg, shok_next;
  logic [31:0] sid_reg, sid_next;
  logic bus_wr, ei, ci, cnb, sc, swap, match;
  logic [31:0] wmask;
  mrs_pkg::mrs_rstat_t rs_view;
  mrs_pkg::mrs_rstat_t wstat;

  assign bus_wr = avs_write && !wait_reg;
  assign wmask = mrs_pkg::be_mask(avs_byteenable);
  assign wstat = mrs_pkg::mrs_rstat_t'(avs_writedata & wmask); // masked status write, field view
  assign ei = link.fig_valid && link.fig_ext == mrs_pkg::EXT_EI;
  assign ci = link.fig_valid && link.fig_ext == mrs_pkg::EXT_CI && !link.cn;
  assign cnb = link.fig_valid && link.fig_ext == mrs_pkg::EXT_CI && link.cn;
  assign sc = link.fig_valid && link.fig_ext == mrs_pkg::EXT_SC;
  // occurrence checked on every CIF, wrap included
  assign swap = link.cif_strobe && rs_reg.pend && (link.cif_low == occ_reg); // [R24] [R19]
  // long form matches the SCId, short form the sub-channel
  assign match = (link.ls == key_reg.ls) && (link.ls ? (link.scid == key_reg.key) // [R4]
    : (link.subch == key_reg.key[5:0])); // [R2]
  assign rs_view = '{svc: rs_reg.svc, shrink: rs_reg.shrink, complete: (prim_reg >= rs_reg.svc), // [R14]
    scids: rs_reg.scids, found: rs_reg.found, known: rs_reg.known, pend: rs_reg.pend,
    alarm: rs_reg.alarm, eid: rs_reg.eid};

  // decoder state and avalon slave
  always_comb begin
    wait_next = !((avs_read || avs_write) && wait_reg);
    rd_next = rd_reg;
    key_next = key_reg;
    rs_next = rs_reg;
    occ_next = occ_reg;
    low_next = low_reg;
    high_next = high_reg;
    cnt_next = cnt_reg;
    shcnt_next = shcnt_reg;
    shsvc_next = shsvc_reg;
    prim_next = prim_reg;
    shok_next = shok_reg;
    sid_next = sid_reg;
    if (avs_read && wait_reg) begin
      unique case (avs_address)
        mrs_pkg::RR_KEY: rd_next = key_reg;
        mrs_pkg::RR_STAT: rd_next = rs_view;
        mrs_pkg::RR_CIF: rd_next = {2'h0, rs_reg.svc, rs_reg.pend, cnt_reg, high_reg, low_reg};
        mrs_pkg::RR_SID: rd_next = sid_reg;
        default: rd_next = '0;
      endcase
    end
    if (bus_wr && avs_address == mrs_pkg::RR_KEY) begin
      key_next = (key_reg & ~wmask) | (avs_writedata & wmask);
      key_next.rsv = '0;
      key_next.rsv0 = '0;
      rs_next.found = 1'b0;
    end
    // software clears the shrink mark; a new event in the same cycle wins
    if (bus_wr && avs_address == mrs_pkg::RR_STAT && wstat.shrink) begin
      rs_next.shrink = 1'b0;
    end
    if (link.shrink_go) begin
      rs_next.shrink = 1'b1; // [R21]
    end
    if (link.cif_strobe) begin
      low_next = link.cif_low;
      high_next = link.cif_high;
    end
    if (ei) begin
      rs_next.eid = link.eid;
      rs_next.alarm = link.alarm; // [R9]
      occ_next = link.occ;
      rs_next.pend = (link.chg != mrs_pkg::CF_NONE); // [R6] [R8]
    end
    if (ci) begin
      rs_next.svc = link.svc; // [R14]
      cnt_next = link.cnt;
      rs_next.known = (link.cnt == key_reg.stored); // [R16]
      prim_next = '0;
    end
    if (cnb) begin
      shsvc_next = link.svc; // [R23]
      shcnt_next = link.cnt;
      shok_next = 1'b1;
    end
    if (sc) begin
      sid_next = link.pd ? link.sid : (link.sid & mrs_pkg::SID16_MASK); // [R3]
      if (link.scids == mrs_pkg::SCIDS_PRI && prim_reg != '1) begin
        prim_next = prim_reg + 1'b1;
      end
      if (match) begin
        rs_next.found = 1'b1;
        rs_next.scids = link.scids;
      end
    end
    if (swap) begin
      if (shok_reg) begin
        rs_next.svc = shsvc_reg; // [R23]
        cnt_next = shcnt_reg;
      end
      rs_next.pend = 1'b0;
      shok_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
      rd_reg <= '0;
      key_reg <= '0;
      rs_reg <= '0;
      occ_reg <= '0;
      low_reg <= '0;
      high_reg <= '0;
      cnt_reg <= '0;
      shcnt_reg <= '0;
      shsvc_reg <= '0;
      prim_reg <= '0;
      shok_reg <= 1'b0;
      sid_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      key_reg <= key_next;
      rs_reg <= rs_next;
      occ_reg <= occ_next;
      low_reg <= low_next;
      high_reg <= high_next;
      cnt_reg <= cnt_next;
      shcnt_reg <= shcnt_next;
      shsvc_reg <= shsvc_next;
      prim_reg <= prim_next;
      shok_reg <= shok_next;
      sid_reg <= sid_next;
    end
  end

  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;
  assign alarm_enable = rs_reg.alarm; // [R9]
endmodule

/* tb/mrs_link_props.sv */
// Purpose: assertions on the link between the two signalling ends
// Assumes: one clk_sys domain, nrst active low
// Notes: instantiated beside the interface in the bench
module mrs_link_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cif_strobe,
  input wire logic [7:0] cif_low,
  input wire logic [4:0] cif_high,
  input wire logic [1:0] frame_pos,
  input wire logic fig_valid,
  input wire logic [4:0] fig_ext,
  input wire logic [1:0] fig_slot,
  input wire logic cn,
  input wire logic [1:0] chg,
  input wire logic [9:0] cnt,
  input wire logic [31:0] sid,
  input wire logic pd,
  input wire logic [3:0] scids
);
  logic [7:0] low_reg;
  logic [4:0] high_reg;
  logic seen_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // remember the count of the previous CIF
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_reg <= 8'h00;
      high_reg <= 5'h00;
      seen_reg <= 1'b0;
    end else if (cif_strobe) begin
      low_reg <= cif_low;
      high_reg <= cif_high;
      seen_reg <= 1'b1;
    end
  end
  chk_low_step: assert property (cif_strobe && seen_reg |->
    cif_low == ((low_reg == mrs_pkg::LOW_LAST) ? 8'h00 : low_reg + 8'h01)) else $error("low count off");
  chk_high_step: assert property (cif_strobe && seen_reg |-> cif_high == ((cif_low != 8'h00) ?
    high_reg : ((high_reg == mrs_pkg::HIGH_LAST) ? 5'h00 : high_reg + 5'h01))) else $error("high count off");
  chk_flags_legal: assert property (fig_valid && fig_ext == mrs_pkg::EXT_EI |->
    chg == mrs_pkg::CF_NONE || chg == mrs_pkg::CF_FULL) else $error("legacy flags sent");
  chk_ens_first: assert property (cif_strobe && frame_pos == mrs_pkg::FRAME_FIRST |-> ##1
    fig_valid && fig_ext == mrs_pkg::EXT_EI && fig_slot == mrs_pkg::SLOT_EI) else $error("ensemble fig misplaced");
  chk_conf_second: assert property (fig_valid && fig_ext == mrs_pkg::EXT_EI |=>
    fig_valid && fig_ext == mrs_pkg::EXT_CI && fig_slot == mrs_pkg::SLOT_CI && !cn) else $error("config fig misplaced");
  chk_next_count: assert property (fig_valid && fig_ext == mrs_pkg::EXT_CI && cn |->
    cnt == $past(cnt) + 10'h001 && fig_slot == mrs_pkg::SLOT_CN) else $error("next count wrong");
  chk_prim_zero: assert property (fig_valid && fig_ext == mrs_pkg::EXT_SC |->
    scids == mrs_pkg::SCIDS_PRI) else $error("primary component id not zero");
  chk_sid_short: assert property (fig_valid && fig_ext == mrs_pkg::EXT_SC && !pd |->
    sid[31:16] == 16'h0000) else $error("short id has upper bits");
  chk_strobe_gap: assert property (cif_strobe |=> !cif_strobe [*8]) else $error("cif strobes too close");
endmodule

/* tb/mrs_tb.sv */
// Purpose: bench for both signalling ends joined by the link
// Assumes: CIF_CYCLES shortened to 16 cycles
// Notes: shared address and data buses, separate strobes per end
module multiplex_reconfig_signalling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] a = 3'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic t_rd = 1'b0, t_wr = 1'b0, r_rd = 1'b0, r_wr = 1'b0;
  logic [31:0] t_q, r_q, q, occ;
  logic t_wait, r_wait, alarm_en;
  int n_fail = 0;
  int checks_done = 0;
  mrs_link_if link_i ();
  mrs_tx_end #(.CIF_CYCLES(16)) u_mrs_tx_end (.clk_sys(clk_sys), .nrst(nrst), .avs_address(a),
    .avs_read(t_rd), .avs_write(t_wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(t_q),
    .avs_waitrequest(t_wait), .link(link_i));
  mrs_rx_end u_mrs_rx_end (.clk_sys(clk_sys), .nrst(nrst), .avs_address(a), .avs_read(r_rd),
    .avs_write(r_wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(r_q),
    .avs_waitrequest(r_wait), .alarm_enable(alarm_en), .link(link_i));
  mrs_link_props u_mrs_link_props (.clk_sys(clk_sys), .nrst(nrst), .cif_strobe(link_i.cif_strobe),
    .cif_low(link_i.cif_low), .cif_high(link_i.cif_high), .frame_pos(link_i.frame_pos),
    .fig_valid(link_i.fig_valid), .fig_ext(link_i.fig_ext), .fig_slot(link_i.fig_slot), .cn(link_i.cn),
    .chg(link_i.chg), .cnt(link_i.cnt), .sid(link_i.sid), .pd(link_i.pd), .scids(link_i.scids));
  always #5 clk_sys = ~clk_sys;
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic s, input logic w, input logic [2:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    a <= ad;
    wd <= d;
    if (s) begin
      r_rd <= !w;
      r_wr <= w;
    end else begin
      t_rd <= !w;
      t_wr <= w;
    end
    do begin
      @(posedge clk_sys);
    end while ((s ? r_wait : t_wait) !== 1'b0);
    q = s ? r_q : t_q;
    {r_rd, r_wr, t_rd, t_wr} <= 4'h0;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, 1, 3'h0, 32'h0001_a5c3);
    acc(0, 0, 3'h0, 32'h0);
    chk(q, 32'h0001_a5c3);
    acc(0, 1, 3'h2, 32'h0000_1234);
    acc(0, 1, 3'h3, 32'h0000_000a);
    acc(1, 1, 3'h0, 32'h0000_0005);
    acc(0, 1, 3'h1, 32'h8000_1003);
    acc(0, 0, 3'h1, 32'h0);
    chk(q & 32'h0180_0000, 32'h0100_0000);
    repeat (100) @(posedge clk_sys);
    acc(1, 0, 3'h1, 32'h0);
    chk(q, 32'h010d_a5c3);
    chk({31'h0, alarm_en}, 32'h1);
    acc(1, 0, 3'h3, 32'h0);
    chk(q, 32'h0000_1234);
    repeat (4000) @(posedge clk_sys);
    acc(0, 1, 3'h1, 32'h8002_0703);
    acc(0, 0, 3'h1, 32'h0);
    chk(q & 32'h0180_0000, 32'h0100_0000);
    acc(0, 0, 3'h4, 32'h0);
    occ = (q[7:0] + 32'h14) % 32'hfa;
    acc(0, 1, 3'h1, 32'h8001_0003 | (occ << 8));
    acc(0, 0, 3'h1, 32'h0);
    chk(q & 32'h0180_0000, 32'h0080_0000);
    repeat (100) @(posedge clk_sys);
    acc(1, 0, 3'h1, 32'h0);
    chk(q & 32'h0002_0000, 32'h0002_0000);
    repeat (320) @(posedge clk_sys);
    acc(0, 0, 3'h4, 32'h0);
    chk(q & 32'h3fff_e000, 32'h0300_2000);
    acc(1, 0, 3'h2, 32'h0);
    chk(q & 32'h3fff_e000, 32'h0300_2000);
    acc(1, 0, 3'h1, 32'h0);
    chk(q & 32'h0200_0000, 32'h0200_0000);
    acc(0, 1, 3'h1, 32'h8000_0003 | (occ << 8));
    acc(0, 0, 3'h1, 32'h0);
    chk(q & 32'h0180_0000, 32'h0100_0000);
    test_done();
  end
  // watchdog against a hung bus or stalled sequence
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule
